// ### rcr_defines.svh
// Register offsets, field positions and reset values of the regulator bank.
// Overview of operation
// [RULE1] Voltage register: six-bit code, top two bits reserved.
// [RULE2] Control bit 7 switches the regulator on.
// [RULE3] Control bit 2 enables discharge while shut down.
// [RULE4] Control bit 1 lets regulator faults interrupt.
// [RULE5] Control bit 0 reads live power-good.
// [RULE6] Pushbutton bit 7 interrupts on button press.
// [RULE7] Pushbutton bit 6 interrupts on button release.
// [RULE8] Bit 1 arms watchdog soft reset.
// [RULE9] Sleep entry clears the soft-reset enable.
// [RULE10] Bit 0 arms watchdog power cycle, sleep clears.
// [RULE11] Reserved bits ignore writes, read zero.
`ifndef RCR_DEFINES_SVH
`define RCR_DEFINES_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define RCR_LDO8_CONTROL_ADDR 8'h69
`define RCR_LDO9_VOLTAGE_SELECT_ADDR 8'h70
`define RCR_LDO9_CONTROL_ADDR 8'h71
`define RCR_LDO10_VOLTAGE_SELECT_ADDR 8'h80
`define RCR_LDO10_CONTROL_ADDR 8'h81
`define RCR_LDO11_VOLTAGE_SELECT_ADDR 8'h90
`define RCR_LDO11_CONTROL_ADDR 8'h91
`define RCR_LDO12_VOLTAGE_SELECT_ADDR 8'ha0
`define RCR_LDO12_CONTROL_ADDR 8'ha1
`define RCR_KEEPALIVE_LDO_CONTROL_ADDR 8'hb1
`define RCR_PUSHBUTTON_WATCHDOG_CONTROL_ADDR 8'hc0

// ****************************************************************
// Field positions.
// ****************************************************************
`define RCR_VOLTAGE_CODE_MSB 5
`define RCR_CTRL_ENABLE_BIT 7
`define RCR_CTRL_DISCHARGE_BIT 2
`define RCR_CTRL_FAULT_IRQ_BIT 1
`define RCR_CTRL_POWER_GOOD_BIT 0
`define RCR_PB_PRESS_IRQ_BIT 7
`define RCR_PB_RELEASE_IRQ_BIT 6
`define RCR_PB_WD_SOFT_RESET_BIT 1
`define RCR_PB_WD_POWER_CYCLE_BIT 0

// ****************************************************************
// Reset values.
// ****************************************************************
`define RCR_VOLTAGE_CODE_RESET 6'h00
`define RCR_BIT_RESET 1'b0

`endif

// ### rcr_pkg.sv
// Types shared by the regulator control register bank.
package rcr_pkg;
    localparam int RCR_NUM_LDO = 5;
    localparam int RCR_NUM_VSEL = 4;

    typedef struct packed {
        logic [RCR_NUM_VSEL-1:0][5:0] voltage_code;
        logic [RCR_NUM_LDO-1:0] enable;
        logic [RCR_NUM_LDO-1:0] discharge;
        logic [RCR_NUM_LDO-1:0] fault_irq_enable;
        logic keepalive_enable;
        logic press_irq_enable;
        logic release_irq_enable;
        logic wd_soft_reset_enable;
        logic wd_power_cycle_enable;
        logic button_prev;
        logic button_irq;
        logic soft_reset_start;
        logic power_cycle_start;
        logic [7:0] rdata;
    } rcr_state_t;
endpackage

// ### rcr_regulator_control_registers.sv
// Byte register bank for the regulators, pushbutton and watchdog.
`timescale 1ns/10ps
`include "rcr_defines.svh"

module rcr_regulator_control_registers
    import rcr_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [7:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [7:0] o_reg_rdata,
    input wire logic [RCR_NUM_LDO-1:0] i_power_good,
    input wire logic [RCR_NUM_LDO-1:0] i_ldo_fault,
    input wire logic i_pushbutton_input,
    input wire logic i_watchdog_expired,
    input wire logic i_sleep_entry,
    output logic [RCR_NUM_VSEL*6-1:0] o_voltage_code,
    output logic [RCR_NUM_LDO-1:0] o_ldo_enable,
    output logic [RCR_NUM_LDO-1:0] o_output_discharge_enable,
    output logic o_keepalive_enable,
    output logic o_fault_irq,
    output logic o_button_irq,
    output logic o_soft_reset_start,
    output logic o_power_cycle_start
);
    rcr_state_t s_q;
    rcr_state_t s_d;

    // ************************************************************
    // Address tables, control index 0 is ldo8, 1 to 4 are ldo9 to ldo12; voltage index 0 to 3 are ldo9 to ldo12.
    // ************************************************************
    localparam logic [7:0] CTRL_ADDR [RCR_NUM_LDO] = '{
        `RCR_LDO8_CONTROL_ADDR, `RCR_LDO9_CONTROL_ADDR,
        `RCR_LDO10_CONTROL_ADDR, `RCR_LDO11_CONTROL_ADDR,
        `RCR_LDO12_CONTROL_ADDR};
    localparam logic [7:0] VSEL_ADDR [RCR_NUM_VSEL] = '{
        `RCR_LDO9_VOLTAGE_SELECT_ADDR, `RCR_LDO10_VOLTAGE_SELECT_ADDR,
        `RCR_LDO11_VOLTAGE_SELECT_ADDR, `RCR_LDO12_VOLTAGE_SELECT_ADDR};

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        logic [7:0] rd;
        logic wr_pb;
        rd = 8'h00;
        s_d = s_q;
        wr_pb = i_reg_wr &&
            (i_reg_addr == `RCR_PUSHBUTTON_WATCHDOG_CONTROL_ADDR);
        for (int i = 0; i < RCR_NUM_VSEL; i++) begin
            if (i_reg_addr == VSEL_ADDR[i]) begin
                // Upper two bits stay zero on read and write.
                rd = {2'b00, s_q.voltage_code[i]}; // [RULE1] [RULE11]
                if (i_reg_wr) begin
                    s_d.voltage_code[i] =
                        i_reg_wdata[`RCR_VOLTAGE_CODE_MSB:0]; // [RULE1]
                end
            end
        end
        for (int i = 0; i < RCR_NUM_LDO; i++) begin
            if (i_reg_addr == CTRL_ADDR[i]) begin
                rd = 8'h00; // [RULE11]
                rd[`RCR_CTRL_ENABLE_BIT] = s_q.enable[i]; // [RULE2]
                rd[`RCR_CTRL_DISCHARGE_BIT] = s_q.discharge[i]; // [RULE3]
                rd[`RCR_CTRL_FAULT_IRQ_BIT] =
                    s_q.fault_irq_enable[i]; // [RULE4]
                rd[`RCR_CTRL_POWER_GOOD_BIT] = i_power_good[i]; // [RULE5]
                if (i_reg_wr) begin
                    s_d.enable[i] =
                        i_reg_wdata[`RCR_CTRL_ENABLE_BIT]; // [RULE2]
                    s_d.discharge[i] =
                        i_reg_wdata[`RCR_CTRL_DISCHARGE_BIT]; // [RULE3]
                    s_d.fault_irq_enable[i] =
                        i_reg_wdata[`RCR_CTRL_FAULT_IRQ_BIT]; // [RULE4]
                end
            end
        end
        if (i_reg_addr == `RCR_KEEPALIVE_LDO_CONTROL_ADDR) begin
            rd = {s_q.keepalive_enable, 7'h00}; // [RULE11]
            if (i_reg_wr) begin
                s_d.keepalive_enable =
                    i_reg_wdata[`RCR_CTRL_ENABLE_BIT]; // [RULE2]
            end
        end
        if (i_reg_addr == `RCR_PUSHBUTTON_WATCHDOG_CONTROL_ADDR) begin
            rd = 8'h00; // [RULE11]
            rd[`RCR_PB_PRESS_IRQ_BIT] = s_q.press_irq_enable;
            rd[`RCR_PB_RELEASE_IRQ_BIT] = s_q.release_irq_enable;
            rd[`RCR_PB_WD_SOFT_RESET_BIT] = s_q.wd_soft_reset_enable;
            rd[`RCR_PB_WD_POWER_CYCLE_BIT] = s_q.wd_power_cycle_enable;
        end
        if (wr_pb) begin
            s_d.press_irq_enable =
                i_reg_wdata[`RCR_PB_PRESS_IRQ_BIT]; // [RULE6]
            s_d.release_irq_enable =
                i_reg_wdata[`RCR_PB_RELEASE_IRQ_BIT]; // [RULE7]
            s_d.wd_soft_reset_enable =
                i_reg_wdata[`RCR_PB_WD_SOFT_RESET_BIT]; // [RULE8]
            s_d.wd_power_cycle_enable =
                i_reg_wdata[`RCR_PB_WD_POWER_CYCLE_BIT]; // [RULE10]
        end
        // Sleep entry overrides a write in the same cycle.
        if (i_sleep_entry) begin
            s_d.wd_soft_reset_enable = 1'b0; // [RULE9]
            s_d.wd_power_cycle_enable = 1'b0; // [RULE10]
        end
        if (i_reg_rd) begin
            s_d.rdata = rd;
        end
        s_d.button_prev = i_pushbutton_input;
        s_d.button_irq =
            (s_q.press_irq_enable && i_pushbutton_input &&
             !s_q.button_prev) || // [RULE6]
            (s_q.release_irq_enable && !i_pushbutton_input &&
             s_q.button_prev); // [RULE7]
        s_d.soft_reset_start =
            i_watchdog_expired && s_q.wd_soft_reset_enable; // [RULE8]
        s_d.power_cycle_start =
            i_watchdog_expired && s_q.wd_power_cycle_enable; // [RULE10]
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign o_reg_rdata = s_q.rdata;
    assign o_voltage_code = s_q.voltage_code;
    assign o_ldo_enable = s_q.enable;
    assign o_output_discharge_enable = s_q.discharge;
    assign o_keepalive_enable = s_q.keepalive_enable;
    assign o_fault_irq = |(i_ldo_fault & s_q.fault_irq_enable); // [RULE4]
    assign o_button_irq = s_q.button_irq;
    assign o_soft_reset_start = s_q.soft_reset_start;
    assign o_power_cycle_start = s_q.power_cycle_start;
endmodule

// ### rcr_regulator_control_registers_sva.sv
// Port checks for the regulator register bank.
`timescale 1ns/10ps
module rcr_regulator_control_registers_sva (
    input logic i_sys_clk, i_sys_rst, i_reg_wr, i_reg_rd,
    input logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
    input logic [4:0] i_power_good, i_ldo_fault, o_ldo_enable,
    input logic i_pushbutton_input, i_watchdog_expired, i_sleep_entry,
    input logic o_fault_irq, o_button_irq, o_soft_reset_start,
    input logic o_power_cycle_start,
    input logic [23:0] o_voltage_code
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    sequence s_wr(x); i_reg_wr && i_reg_addr == x; endsequence
    sequence s_nap; i_sleep_entry ##1 i_watchdog_expired; endsequence
    chk_code_write: assert property (s_wr(8'h70) |=>
        o_voltage_code[5:0] == $past(i_reg_wdata[5:0])) else $error("code");
    chk_enable_write: assert property (s_wr(8'h71) |=>
        o_ldo_enable[1] == $past(i_reg_wdata[7])) else $error("enable");
    chk_fault_cause: assert property (o_fault_irq |->
        i_ldo_fault != 0) else $error("fault irq");
    chk_status_read: assert property (
        i_reg_rd && i_reg_addr == 8'h71 |=> o_reg_rdata[6:3] == 0 &&
        o_reg_rdata[0] == $past(i_power_good[1])) else $error("status");
    chk_button_edge: assert property (o_button_irq |->
        $past(i_pushbutton_input) != $past(i_pushbutton_input, 2))
        else $error("button irq");
    chk_soft_cause: assert property (o_soft_reset_start |->
        $past(i_watchdog_expired)) else $error("soft reset");
    chk_cycle_cause: assert property (o_power_cycle_start |->
        $past(i_watchdog_expired)) else $error("power cycle");
    chk_sleep_clear: assert property (s_nap |=>
        !o_soft_reset_start && !o_power_cycle_start) else $error("sleep");
endmodule

// ### rcr_ldo_model.sv
// Regulator stand-in: power good follows its enable one cycle later.
`timescale 1ns/10ps
module rcr_ldo_model (
    input wire logic i_sys_clk,
    input wire logic [4:0] i_ldo_enable,
    output logic [4:0] o_power_good
);
    always_ff @(posedge i_sys_clk) o_power_good <= i_ldo_enable;
endmodule

// ### tb_top.sv
// Self-checking bench for the regulator register bank.
`timescale 1ns/10ps
module tb_top;
    logic clk = 0, rst = 1, wr = 0, rd = 0, pb = 0, wde = 0, slp = 0;
    logic [7:0] ad = 0, wd = 0, rdt;
    logic [4:0] pg, flt = 0, en, dis;
    logic [23:0] vc;
    logic ka, fi, bi, sr, pc;
    int fails = 0, check_count = 0;
    logic [7:0] ctl [5] = '{8'h69, 8'h71, 8'h81, 8'h91, 8'ha1};
    always #50 clk = ~clk;
    rcr_regulator_control_registers rcr_regulator_control_registers_inst (
        .i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(ad), .i_reg_wr(wr),
        .i_reg_wdata(wd), .i_reg_rd(rd), .o_reg_rdata(rdt),
        .i_power_good(pg), .i_ldo_fault(flt), .i_pushbutton_input(pb),
        .i_watchdog_expired(wde), .i_sleep_entry(slp), .o_voltage_code(vc),
        .o_ldo_enable(en), .o_output_discharge_enable(dis),
        .o_keepalive_enable(ka), .o_fault_irq(fi), .o_button_irq(bi),
        .o_soft_reset_start(sr), .o_power_cycle_start(pc));
    rcr_ldo_model rcr_ldo_model_inst (.i_sys_clk(clk), .i_ldo_enable(en),
        .o_power_good(pg));
    task chk(input logic [23:0] s, input logic [23:0] e, input string n);
        check_count++;
        if (s !== e) fails++;
        if (s !== e) $display("BAD %s expected %h seen %h", n, e, s);
    endtask
    task wr_reg(input logic [7:0] a, input logic [7:0] d);
        {ad, wd, wr} = {a, d, 1'b1};
        @(posedge clk) #1 wr = 0;
    endtask
    task rd_reg(input logic [7:0] a, input logic [7:0] e, input string n);
        {ad, rd} = {a, 1'b1};
        @(posedge clk) #1 rd = 0;
        chk(rdt, e, n);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 0;
        rd_reg(8'hc0, 0, "pb_reset");
        for (int i = 0; i < 4; i++) begin
            wr_reg(8'h70 + 8'(16 * i), 8'hc1 + 8'(i));
            rd_reg(8'h70 + 8'(16 * i), 8'(i + 1), "vsel");
        end
        chk(vc, 24'h10_3081, "vcode");
        foreach (ctl[i]) wr_reg(ctl[i], 8'hff);
        foreach (ctl[i]) rd_reg(ctl[i], 8'h87, "ctl_on");
        foreach (ctl[i]) wr_reg(ctl[i], 8'h7e);
        foreach (ctl[i]) rd_reg(ctl[i], 8'h06, "ctl_off");
        chk({en, dis}, 10'h01f, "en_dis");
        flt = 5'h10;
        #1 chk(fi, 1, "fault_on");
        wr_reg(8'ha1, 8'h04);
        chk(fi, 0, "fault_off");
        wr_reg(8'h68, 8'hff);
        rd_reg(8'h68, 0, "unmapped");
        wr_reg(8'hc0, 8'hff);
        rd_reg(8'hc0, 8'hc3, "pb_reg");
        repeat (2) begin
            pb = ~pb;
            @(posedge clk) #1 chk(bi, 1, "btn_irq");
            @(posedge clk) #1 chk(bi, 0, "btn_once");
        end
        wr_reg(8'hc0, 8'h03);
        pb = 1;
        @(posedge clk) #1 chk(bi, 0, "btn_masked");
        wde = 1;
        @(posedge clk) #1 wde = 0;
        chk({sr, pc}, 2'b11, "wd_start");
        slp = 1;
        @(posedge clk) #1 {slp, wde} = 2'b01;
        @(posedge clk) #1 wde = 0;
        chk({sr, pc}, 0, "wd_asleep");
        rd_reg(8'hc0, 0, "pb_sleep");
        chk(ka, 0, "ka_reset");
        wr_reg(8'hb1, 8'hff);
        rd_reg(8'hb1, 8'h80, "ka_reg");
        chk(ka, 1, "ka_on");
        wr_reg(8'hb1, 8'h7f);
        chk(ka, 0, "ka_off");
        give_verdict;
    end
endmodule
bind rcr_regulator_control_registers rcr_regulator_control_registers_sva
    rcr_regulator_control_registers_sva_inst (.*);
